// ---- dcc_core_control.sv ----
// dsp core control register bank with its satellite data registers
`default_nettype none
module dcc_core_control (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // control port
  input  wire logic                            ctrl_wr,
  input  wire logic                            ctrl_rd,
  input  wire logic [dcc_pkg::ADDR_W-1:0]      ctrl_addr,
  input  wire logic [dcc_pkg::DATA_W-1:0]      ctrl_wdata,
  output var  logic [dcc_pkg::DATA_W-1:0]      ctrl_rdata,
  // dsp program writes to interface registers
  input  wire logic                            dsp_iface_we,
  input  wire logic [2:0]                      dsp_iface_idx,
  input  wire logic [dcc_pkg::DATA_W-1:0]      dsp_iface_data,
  // multipurpose pin sources
  input  wire logic [dcc_pkg::DATA_W-1:0]      mp_gpio_in,
  input  wire logic                            mp_aux_we,
  input  wire logic [1:0]                      mp_aux_idx,
  input  wire logic [dcc_pkg::DATA_W-1:0]      mp_aux_data,
  // register contents toward the core
  output var  logic [dcc_pkg::DATA_W-1:0]      iface_regs [dcc_pkg::NUM_IFACE],
  output var  logic [dcc_pkg::DATA_W-1:0]      gpio_setting,
  output var  logic [dcc_pkg::DATA_W-1:0]      aux_adc_regs [dcc_pkg::NUM_AUX],
  // core controls
  output var  logic                            adc_mute_n,
  output var  logic                            dac_mute_n,
  output var  logic                            core_run,
  output var  logic [1:0]                      rate_select,
  output var  logic [10:0]                     instr_per_sample,
  output var  logic [2:0]                      conv_rate_mult,
  output var  logic [1:0]                      gpio_debounce,
  // parameter ram write port
  output var  logic                            pram_we,
  output var  logic [dcc_pkg::PRAM_ADDR_W-1:0] pram_addr,
  output var  logic [dcc_pkg::DATA_W-1:0]      pram_wdata
);

  // ------------------------------------------------------------------
  // storage
  // ------------------------------------------------------------------
  logic [15:0] ctrl_reg;
  logic [15:0] iface_reg    [dcc_pkg::NUM_IFACE];
  logic [15:0] gpio_reg;
  logic [15:0] aux_reg      [dcc_pkg::NUM_AUX];
  logic [15:0] rdata_reg;

  dcc_sl_if sl ();

  // control bit aliases
  logic gpio_pin_write_override;
  logic iface_reg_host_write;
  logic aux_adc_host_write;
  logic safeload_start;

  assign gpio_pin_write_override = ctrl_reg[dcc_pkg::BIT_GPIO_OVR];
  assign iface_reg_host_write    = ctrl_reg[dcc_pkg::BIT_IFACE_HW];
  assign aux_adc_host_write      = ctrl_reg[dcc_pkg::BIT_AUX_HW];
  assign safeload_start          = ctrl_reg[dcc_pkg::BIT_SL_START];

  // ------------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------------
  logic        hit_ctrl;
  logic        hit_iface;
  logic        hit_gpio;
  logic        hit_aux;
  logic        hit_sl_addr;
  logic        hit_sl_data;
  logic [11:0] off_iface;
  logic [11:0] off_aux;
  logic [11:0] off_sl_addr;
  logic [11:0] off_sl_data;

  localparam logic [11:0] SLOTS_12 = 12'(dcc_pkg::NUM_SLOTS);

  assign off_iface   = ctrl_addr - dcc_pkg::ADDR_IFACE_FIRST;
  assign off_aux     = ctrl_addr - dcc_pkg::ADDR_AUX_FIRST;
  assign off_sl_addr = ctrl_addr - dcc_pkg::ADDR_SL_ADDR0;
  assign off_sl_data = ctrl_addr - dcc_pkg::ADDR_SL_DATA0;

  assign hit_ctrl    = (ctrl_addr == dcc_pkg::ADDR_CORE_CTRL);
  assign hit_gpio    = (ctrl_addr == dcc_pkg::ADDR_GPIO_SET);
  assign hit_iface   = (ctrl_addr >= dcc_pkg::ADDR_IFACE_FIRST)
                       && (ctrl_addr <= dcc_pkg::ADDR_IFACE_LAST);
  assign hit_aux     = (ctrl_addr >= dcc_pkg::ADDR_AUX_FIRST)
                       && (ctrl_addr <= dcc_pkg::ADDR_AUX_LAST);
  assign hit_sl_addr = (ctrl_addr >= dcc_pkg::ADDR_SL_ADDR0)
                       && (off_sl_addr < SLOTS_12);
  assign hit_sl_data = (ctrl_addr >= dcc_pkg::ADDR_SL_DATA0)
                       && (off_sl_data < SLOTS_12);

  // ------------------------------------------------------------------
  // core control register
  // ------------------------------------------------------------------
  // start can only be raised by the host and only dropped by the engine,
  // so a late write of zero cannot abort a copy half way through
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= dcc_pkg::CORE_CTRL_RESET;
    end else begin
      // clear first, so a start written in the done cycle still lands
      if (sl.done) begin
        ctrl_reg[dcc_pkg::BIT_SL_START] <= 1'b0;
      end
      if (ctrl_wr && hit_ctrl) begin
        ctrl_reg[15:6] <= ctrl_wdata[15:6] & dcc_pkg::CORE_CTRL_MASK[15:6];
        ctrl_reg[4:0]  <= ctrl_wdata[4:0];
        if (ctrl_wdata[dcc_pkg::BIT_SL_START]) begin
          ctrl_reg[dcc_pkg::BIT_SL_START] <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // interface registers
  // ------------------------------------------------------------------
  // host owns them while host write is on; the program is locked out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dcc_pkg::NUM_IFACE; i++) begin
        iface_reg[i] <= 16'h0000;
      end
    end else if (iface_reg_host_write) begin
      if (ctrl_wr && hit_iface) begin
        iface_reg[off_iface[2:0]] <= ctrl_wdata;
      end
    end else if (dsp_iface_we) begin
      iface_reg[dsp_iface_idx] <= dsp_iface_data;
    end
  end

  // ------------------------------------------------------------------
  // gpio pin setting register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gpio_reg <= 16'h0000;
    end else if (gpio_pin_write_override) begin
      if (ctrl_wr && hit_gpio) begin
        gpio_reg <= ctrl_wdata;
      end
    end else begin
      gpio_reg <= mp_gpio_in;  // follows pins only without override
    end
  end

  // ------------------------------------------------------------------
  // auxiliary adc data registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < dcc_pkg::NUM_AUX; i++) begin
        aux_reg[i] <= 16'h0000;
      end
    end else if (aux_adc_host_write) begin
      if (ctrl_wr && hit_aux) begin
        aux_reg[off_aux[1:0]] <= ctrl_wdata;
      end
    end else if (mp_aux_we) begin
      aux_reg[mp_aux_idx] <= mp_aux_data;
    end
  end

  // ------------------------------------------------------------------
  // safeload slots
  // ------------------------------------------------------------------
  // a write to either half of a slot marks it pending; a write landing
  // in the same cycle the engine consumes it keeps it pending
  for (genvar s = 0; s < dcc_pkg::NUM_SLOTS; s++) begin : g_slot
    logic wr_a;
    logic wr_d;
    assign wr_a = ctrl_wr && hit_sl_addr && (off_sl_addr == 12'(s));
    assign wr_d = ctrl_wr && hit_sl_data && (off_sl_data == 12'(s));

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sl.slot_addr[s] <= '0;
        sl.slot_data[s] <= '0;
      end else begin
        if (wr_a) begin
          sl.slot_addr[s] <= ctrl_wdata[dcc_pkg::PRAM_ADDR_W-1:0];
        end
        if (wr_d) begin
          sl.slot_data[s] <= ctrl_wdata;
        end
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sl.pending[s] <= 1'b0;
      end else if (wr_a || wr_d) begin
        sl.pending[s] <= 1'b1;
      end else if (sl.consume[s]) begin
        sl.pending[s] <= 1'b0;
      end
    end
  end

  // start is a level; the engine only looks at it while idle
  assign sl.start = safeload_start;

  dcc_safeload u_safeload (
    .clk        (clk),
    .rst_n      (rst_n),
    .sl         (sl),
    .pram_we    (pram_we),
    .pram_addr  (pram_addr),
    .pram_wdata (pram_wdata)
  );

  // ------------------------------------------------------------------
  // read path, one cycle after the read strobe
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (ctrl_rd) begin
      if (hit_ctrl) begin
        rdata_reg <= ctrl_reg;  // live start bit lets the host poll
      end else if (hit_iface) begin
        rdata_reg <= iface_reg[off_iface[2:0]];
      end else if (hit_gpio) begin
        rdata_reg <= gpio_reg;
      end else if (hit_aux) begin
        rdata_reg <= aux_reg[off_aux[1:0]];
      end else if (hit_sl_addr) begin
        rdata_reg <= 16'(sl.slot_addr[off_sl_addr[2:0]]);
      end else if (hit_sl_data) begin
        rdata_reg <= sl.slot_data[off_sl_data[2:0]];
      end else begin
        rdata_reg <= 16'h0000;  // unmapped reads as zero
      end
    end
  end
  assign ctrl_rdata = rdata_reg;

  // ------------------------------------------------------------------
  // outputs toward the core
  // ------------------------------------------------------------------
  assign adc_mute_n    = ctrl_reg[dcc_pkg::BIT_ADC_MUTE];
  assign dac_mute_n    = ctrl_reg[dcc_pkg::BIT_DAC_MUTE];
  assign core_run      = ctrl_reg[dcc_pkg::BIT_CORE_RUN];
  assign rate_select   = ctrl_reg[dcc_pkg::BIT_RATE_LO +: 2];
  assign gpio_debounce = ctrl_reg[dcc_pkg::BIT_DEBNC_LO +: 2];
  assign gpio_setting  = gpio_reg;
  always_comb begin
    for (int i = 0; i < dcc_pkg::NUM_IFACE; i++) begin
      iface_regs[i] = iface_reg[i];
    end
    for (int i = 0; i < dcc_pkg::NUM_AUX; i++) begin
      aux_adc_regs[i] = aux_reg[i];
    end
  end

  // rate decode; the reserved code falls back to single rate so the
  // core never sees an undefined program length
  always_comb begin
    unique case (dcc_pkg::dcc_rate_t'(rate_select))
      dcc_pkg::DCC_RATE_1X: begin
        instr_per_sample = dcc_pkg::IPS_1X;
        conv_rate_mult   = dcc_pkg::CONV_MULT_1X;
      end
      dcc_pkg::DCC_RATE_2X: begin
        instr_per_sample = dcc_pkg::IPS_2X;
        conv_rate_mult   = dcc_pkg::CONV_MULT_2X;
      end
      dcc_pkg::DCC_RATE_4X: begin
        instr_per_sample = dcc_pkg::IPS_4X;
        conv_rate_mult   = dcc_pkg::CONV_MULT_4X;
      end
      dcc_pkg::DCC_RATE_RSV: begin
        instr_per_sample = dcc_pkg::IPS_1X;
        conv_rate_mult   = dcc_pkg::CONV_MULT_1X;
      end
    endcase
  end

endmodule
`default_nettype wire

// ---- dcc_pkg.sv ----
// constants shared by the dsp core control register block
`default_nettype none
package dcc_pkg;

  // --------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------
  localparam int ADDR_W      = 12;
  localparam int DATA_W      = 16;
  localparam int PRAM_ADDR_W = 10;
  localparam int NUM_SLOTS   = 5;
  localparam int NUM_IFACE   = 8;
  localparam int NUM_AUX     = 4;
  localparam int SLOT_IDX_W  = 3;

  // --------------------------------------------------------------------
  // control port addresses
  // --------------------------------------------------------------------
  localparam logic [11:0] ADDR_IFACE_FIRST = 12'h800;  // 2048
  localparam logic [11:0] ADDR_IFACE_LAST  = 12'h807;  // 2055
  localparam logic [11:0] ADDR_GPIO_SET    = 12'h808;  // 2056
  localparam logic [11:0] ADDR_AUX_FIRST   = 12'h809;  // 2057
  localparam logic [11:0] ADDR_AUX_LAST    = 12'h80C;  // 2060
  localparam logic [11:0] ADDR_SL_ADDR0    = 12'h810;  // five address regs
  localparam logic [11:0] ADDR_SL_DATA0    = 12'h815;  // five data regs
  localparam logic [11:0] ADDR_CORE_CTRL   = 12'h81C;  // 2076

  // --------------------------------------------------------------------
  // core control register fields
  // --------------------------------------------------------------------
  localparam int BIT_RATE_LO   = 0;
  localparam int BIT_CORE_RUN  = 2;
  localparam int BIT_DAC_MUTE  = 3;
  localparam int BIT_ADC_MUTE  = 4;
  localparam int BIT_SL_START  = 5;
  localparam int BIT_IFACE_HW  = 6;
  localparam int BIT_GPIO_OVR  = 7;
  localparam int BIT_AUX_HW    = 8;
  localparam int BIT_DEBNC_LO  = 12;
  localparam logic [15:0] CORE_CTRL_MASK  = 16'h31FF;  // reserved read 0
  localparam logic [15:0] CORE_CTRL_RESET = 16'h0000;

  // --------------------------------------------------------------------
  // sample rate codes
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCC_RATE_1X  = 2'b00,
    DCC_RATE_2X  = 2'b01,
    DCC_RATE_4X  = 2'b10,
    DCC_RATE_RSV = 2'b11
  } dcc_rate_t;

  localparam logic [10:0] IPS_1X = 11'h400;  // 1024
  localparam logic [10:0] IPS_2X = 11'h200;  // 512
  localparam logic [10:0] IPS_4X = 11'h100;  // 256
  localparam logic [2:0]  CONV_MULT_1X = 3'h1;
  localparam logic [2:0]  CONV_MULT_2X = 3'h2;
  localparam logic [2:0]  CONV_MULT_4X = 3'h4;  // 192 kHz converters

  // safeload engine states, gray along idle -> copy -> done
  typedef enum logic [1:0] {
    DCC_SL_IDLE = 2'b00,
    DCC_SL_COPY = 2'b01,
    DCC_SL_DONE = 2'b11
  } dcc_sl_state_t;

endpackage
`default_nettype wire

// ---- dcc_sl_if.sv ----
// link between the register bank and the safeload engine
`default_nettype none
interface dcc_sl_if;
  logic                                start;
  logic [dcc_pkg::NUM_SLOTS-1:0]       pending;
  logic [dcc_pkg::PRAM_ADDR_W-1:0]     slot_addr [dcc_pkg::NUM_SLOTS];
  logic [dcc_pkg::DATA_W-1:0]          slot_data [dcc_pkg::NUM_SLOTS];
  logic [dcc_pkg::NUM_SLOTS-1:0]       consume;
  logic                                done;

  modport bank   (output start, pending, slot_addr, slot_data,
                  input consume, done);
  modport engine (input start, pending, slot_addr, slot_data,
                  output consume, done);
endinterface
`default_nettype wire

// ---- dcc_safeload.sv ----
// safeload engine: copies written slots into parameter ram
`default_nettype none
module dcc_safeload (
  // clock and reset
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  // link to register bank
  dcc_sl_if.engine                             sl,
  // parameter ram write port
  output var  logic                            pram_we,
  output var  logic [dcc_pkg::PRAM_ADDR_W-1:0] pram_addr,
  output var  logic [dcc_pkg::DATA_W-1:0]      pram_wdata
);

  dcc_pkg::dcc_sl_state_t state_reg;
  logic [dcc_pkg::SLOT_IDX_W-1:0] idx_reg;

  localparam logic [2:0] LAST_SLOT = 3'(dcc_pkg::NUM_SLOTS - 1);

  // ------------------------------------------------------------------
  // sequencer: one slot per cycle, slots 0..4 in order
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= dcc_pkg::DCC_SL_IDLE;
      idx_reg   <= 3'h0;
    end else begin
      unique case (state_reg)
        dcc_pkg::DCC_SL_IDLE: begin
          idx_reg <= 3'h0;
          if (sl.start) begin
            state_reg <= dcc_pkg::DCC_SL_COPY;
          end
        end
        dcc_pkg::DCC_SL_COPY: begin
          if (idx_reg == LAST_SLOT) begin
            state_reg <= dcc_pkg::DCC_SL_DONE;
          end else begin
            idx_reg <= idx_reg + 3'h1;
          end
        end
        dcc_pkg::DCC_SL_DONE: begin
          state_reg <= dcc_pkg::DCC_SL_IDLE;
        end
        default: begin
          state_reg <= dcc_pkg::DCC_SL_IDLE;
        end
      endcase
    end
  end

  // ------------------------------------------------------------------
  // ram write: only slots written since the last event go out
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pram_we    <= 1'b0;
      pram_addr  <= '0;
      pram_wdata <= '0;
    end else begin
      pram_we <= (state_reg == dcc_pkg::DCC_SL_COPY)
                 && sl.pending[idx_reg];
      if (state_reg == dcc_pkg::DCC_SL_COPY) begin
        pram_addr  <= sl.slot_addr[idx_reg];
        pram_wdata <= sl.slot_data[idx_reg];
      end
    end
  end

  // consume clears a slot's pending flag; done ends the start bit
  always_comb begin
    sl.consume = '0;
    if (state_reg == dcc_pkg::DCC_SL_COPY) begin
      sl.consume[idx_reg] = sl.pending[idx_reg];
    end
  end
  assign sl.done = (state_reg == dcc_pkg::DCC_SL_DONE);

endmodule
`default_nettype wire

// ---- dcc_core_control_asserts.sv ----
// assertion checker for the dsp core control register bank
`default_nettype none
module dcc_core_control_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // control port
  input wire logic        ctrl_wr,
  input wire logic        ctrl_rd,
  input wire logic [11:0] ctrl_addr,
  input wire logic [15:0] ctrl_wdata,
  input wire logic [15:0] ctrl_rdata,
  // core and pin sources
  input wire logic        dsp_iface_we,
  input wire logic [2:0]  dsp_iface_idx,
  input wire logic        mp_aux_we,
  input wire logic [1:0]  mp_aux_idx,
  // register outputs
  input wire logic [15:0] iface_regs [8],
  input wire logic [15:0] gpio_setting,
  input wire logic [15:0] aux_adc_regs [4],
  input wire logic        adc_mute_n,
  input wire logic        dac_mute_n,
  input wire logic        core_run,
  input wire logic [1:0]  rate_select,
  input wire logic [10:0] instr_per_sample,
  input wire logic [2:0]  conv_rate_mult,
  input wire logic        pram_we
);
  logic       ctl_wr;
  logic       ovr_q;
  logic       ifhw_q;
  logic       aux_q;
  logic [3:0] sl_cnt;
  assign ctl_wr = ctrl_wr && ctrl_addr == 12'h81C;
  // shadow of the host-write bits, which have no pins of their own
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) {aux_q, ovr_q, ifhw_q} <= 3'h0;
    else if (ctl_wr) {aux_q, ovr_q, ifhw_q} <= ctrl_wdata[8:6];
  end
  // cycles since the last start write, saturating so it never wraps
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sl_cnt <= 4'hF;
    else if (ctl_wr && ctrl_wdata[5]) sl_cnt <= 4'h0;
    else if (sl_cnt != 4'hF) sl_cnt <= sl_cnt + 4'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  rate_ips_a: assert property (
    instr_per_sample == (rate_select == 2'h1 ? 11'h200 :
                         rate_select == 2'h2 ? 11'h100 : 11'h400))
    else $error("instructions per sample do not match rate code");
  conv_mult_a: assert property (
    conv_rate_mult == (rate_select == 2'h2 ? 3'h4 :
                       rate_select == 2'h1 ? 3'h2 : 3'h1))
    else $error("converter rate does not match rate code");
  mute_wr_a: assert property (
    ctl_wr |=> {adc_mute_n, dac_mute_n} == $past(ctrl_wdata[4:3]))
    else $error("mute outputs did not take written bits");
  run_rate_a: assert property (
    ctl_wr |=> {core_run, rate_select} == $past(ctrl_wdata[2:0]))
    else $error("core run or rate did not take written bits");
  gpio_hold_a: assert property (
    ovr_q && !ctrl_wr |=> $stable(gpio_setting))
    else $error("gpio setting moved while overridden");
  iface_lock_a: assert property (
    ifhw_q && dsp_iface_we && dsp_iface_idx == 3'h0 && !ctrl_wr
    |=> $stable(iface_regs[0]))
    else $error("dsp write landed while host owns interface regs");
  aux_lock_a: assert property (
    aux_q && mp_aux_we && mp_aux_idx == 2'h0 && !ctrl_wr
    |=> $stable(aux_adc_regs[0]))
    else $error("pin update landed while host owns aux regs");
  pram_cause_a: assert property (
    pram_we |-> sl_cnt < 4'hA)
    else $error("parameter ram written without a start");
  read_back_a: assert property (
    ctrl_rd && ctrl_addr == 12'h81C |=> ctrl_rdata[4:0] ==
      $past({adc_mute_n, dac_mute_n, core_run, rate_select}))
    else $error("control register read back wrong");
endmodule
bind dcc_core_control dcc_core_control_chk dcc_core_control_chk_i (.*);
`default_nettype wire

// ---- dcc_host_model.sv ----
// behavioural host driving the control port
`default_nettype none
module dcc_host_model (
  // clock
  input  wire logic        clk,
  // control port toward the device
  output var  logic        ctrl_wr,
  output var  logic        ctrl_rd,
  output var  logic [11:0] ctrl_addr,
  output var  logic [15:0] ctrl_wdata,
  input  wire logic [15:0] ctrl_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle port; rate stays 1x until the caller asks otherwise
  initial {ctrl_wr, ctrl_rd, ctrl_addr, ctrl_wdata} = '0;
  // one write; safeload is only ever started by such a write
  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    @(negedge clk);
    ctrl_wr = 1'b1;
    ctrl_addr = a;
    // reserved rate code is never sent
    ctrl_wdata = (a == 12'h81C && d[1:0] == 2'h3) ? {d[15:2], 2'h0} : d;
    @(negedge clk);
    ctrl_wr = 1'b0;
    ctrl_addr = ~a;  // released lines must not look valid
    ctrl_wdata = ~ctrl_wdata;
  endtask
  // one read; data is there the cycle after the strobe edge
  task automatic rd(input logic [11:0] a, output logic [15:0] d);
    @(negedge clk);
    ctrl_rd = 1'b1;
    ctrl_addr = a;
    @(negedge clk);
    ctrl_rd = 1'b0;
    ctrl_addr = ~a;
    d = ctrl_rdata;
  endtask
endmodule
`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the dsp core control register bank
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, rst_n, ctrl_wr, ctrl_rd, dsp_iface_we, mp_aux_we;
  logic        adc_mute_n, dac_mute_n, core_run, pram_we;
  logic [11:0] ctrl_addr;
  logic [15:0] ctrl_wdata, ctrl_rdata, dsp_iface_data, mp_gpio_in, rv;
  logic [15:0] mp_aux_data, gpio_setting, pram_wdata, m_ctl;
  logic [15:0] iface_regs [8], aux_adc_regs [4], m_if [8], m_ax [4];
  logic [2:0]  dsp_iface_idx, conv_rate_mult;
  logic [1:0]  mp_aux_idx, rate_select, gpio_debounce;
  logic [10:0] instr_per_sample;
  logic [9:0]  pram_addr, sa;
  logic [31:0] seed = 32'hcd7d;
  logic [25:0] seen [$], want [$];
  int          err_total, comparisons, cyc;
  dcc_core_control dcc_core_control_i (.*);
  dcc_host_model dcc_host_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [15:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic set_ctl(input logic [15:0] v);
    dcc_host_model_i.wr(12'h81C, v);
    m_ctl = v & 16'h31FF;  // reserved bits read back zero
  endtask
  task automatic ctl_chk();
    dcc_host_model_i.rd(12'h81C, rv);
    chk(rv, m_ctl);
    chk({adc_mute_n, dac_mute_n, core_run, rate_select}, m_ctl[4:0]);
    chk(gpio_debounce, m_ctl[13:12]);
  endtask
  // dsp program and pin side update in the same cycle
  task automatic side(input logic [2:0] i, input logic [15:0] d, a);
    {dsp_iface_we, dsp_iface_idx, dsp_iface_data} = {1'b1, i, d};
    {mp_aux_we, mp_aux_idx, mp_aux_data} = {1'b1, i[1:0], a};
    @(negedge clk);
    {dsp_iface_we, mp_aux_we} = 2'b00;
    @(negedge clk);
  endtask
  task automatic cmp_side();
    for (int i = 0; i < 8; i++) chk(iface_regs[i], m_if[i]);
    for (int i = 0; i < 4; i++) chk(aux_adc_regs[i], m_ax[i]);
  endtask
  // start, poll bounded for self-clear, then compare copied slots
  task automatic sl_run();
    set_ctl(m_ctl | 16'h0020);
    dcc_host_model_i.rd(12'h81C, rv);
    chk(rv[5], 1'b1);
    m_ctl[5] = 1'b0;
    for (int i = 0; i < 20 && rv[5] !== 1'b0; i++)
      dcc_host_model_i.rd(12'h81C, rv);
    chk(rv, m_ctl);
    chk(seen.size(), want.size());
    while (want.size() > 0 && seen.size() > 0)
      chk(seen.pop_front(), want.pop_front());
    seen.delete();
    want.delete();
  endtask
  // capture of parameter ram writes; cycle ceiling against hangs
  always @(negedge clk) begin
    cyc++;
    if (pram_we === 1'b1) seen.push_back({pram_addr, pram_wdata});
    if (cyc == 5000) begin
      err_total++;
      end_sim();
    end
  end
  initial begin
    rst_n = 1'b0;
    {dsp_iface_we, dsp_iface_idx, dsp_iface_data} = '0;
    {mp_aux_we, mp_aux_idx, mp_aux_data, mp_gpio_in} = '0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    m_ctl = 16'h0000;
    ctl_chk();
    chk(instr_per_sample, 32'h400);
    $display("reset test done");
    for (int r = 0; r < 3; r++) begin
      set_ctl(16'hCE1C | 16'(r));
      ctl_chk();
      chk(instr_per_sample, 32'h400 >> r);
      chk(conv_rate_mult, 32'h1 << r);
    end
    set_ctl(16'h3000);
    ctl_chk();
    $display("rate test done");
    mp_gpio_in = rnd();
    dcc_host_model_i.wr(12'h808, ~mp_gpio_in);
    chk(gpio_setting, mp_gpio_in);
    set_ctl(16'h0080);
    rv = rnd();
    dcc_host_model_i.wr(12'h808, rv);
    mp_gpio_in = ~rv;
    repeat (2) @(negedge clk);
    chk(gpio_setting, rv);
    $display("gpio test done");
    for (int i = 0; i < 8; i++) begin
      m_if[i] = rnd();
      m_ax[i%4] = rnd();
      side(3'(i), m_if[i], m_ax[i%4]);
    end
    dcc_host_model_i.wr(12'h800, 16'h0000);
    dcc_host_model_i.wr(12'h809, 16'h0000);
    cmp_side();
    set_ctl(16'h0140);
    for (int i = 0; i < 12; i++) begin
      rv = rnd();
      if (i < 8) m_if[i] = rv;
      else m_ax[i-8] = rv;
      dcc_host_model_i.wr(12'h800 + 12'(i) + 12'(i / 8), rv);
    end
    side(3'h0, ~m_if[0], ~m_ax[0]);
    cmp_side();
    dcc_host_model_i.rd(12'h800, rv);
    chk(rv, m_if[0]);
    $display("host write test done");
    for (int s = 0; s < 5; s += 3) begin
      rv = rnd();
      sa = rv[9:0];
      dcc_host_model_i.wr(12'h810 + 12'(s), rv);
      rv = rnd();
      dcc_host_model_i.wr(12'h815 + 12'(s), rv);
      want.push_back({sa, rv});
    end
    sl_run();
    sl_run();
    rv = rnd();
    dcc_host_model_i.wr(12'h814, rv);
    want.push_back({rv[9:0], 16'h0000});
    sl_run();
    $display("safeload test done");
    end_sim();
  end
endmodule
`default_nettype wire
